// [design/media_pipe_command_sequencer.sv]
// media command sequencer: tracks the command stream order and latches state
// assumes cmdValid/cmdCode/cmdData come from logic on the same clock
//------------------------------------------------------------
// declarations
//------------------------------------------------------------
// Summary of operation
// - register write disables vertex cache path
// - register write re-enables vertex cache streaming
// - at most one partition fence per flush
// - repeated state command keeps last value; only base, pointers, streamer and routine payloads are stored
// - remaining state commands accepted any order
// - at most one constant buffer per flush
module media_pipe_command_sequencer (
  input wire logic clk,
  input wire logic srst,
  input wire logic cmdValid,
  input wire logic [4:0] cmdCode,
  input wire logic [31:0] cmdData,
  input wire logic [31:0] readSlotSel,
  output logic cmdAccept,
  output logic orderError,
  output logic undefinedError,
  output logic [31:0] vertexCacheCtrl,
  output logic vertexCacheStreaming,
  output logic objectLaunch,
  output logic [31:0] slotReadData,
  output logic [2:0] phaseOut
);
  media_seq_pkg::phase_e phase;
  media_seq_pkg::phase_e next_phase;
  logic fenceSeen;
  logic constSeen;
  logic ptrsSeen;
  logic stepOk;
  logic stateBad;
  logic regDataDue;
  logic regToVc;
  logic [31:0] slotData;
  state_slot_if slot ();

  state_slot_store store (
    .clk(clk),
    .srst(srst),
    .slot(slot)
  );

  //------------------------------------------------------------
  // command decode and ordering
  //------------------------------------------------------------
  wire isFlush = cmdValid && cmdCode == media_seq_pkg::CMD_FLUSH;
  wire isSelect = cmdValid && cmdCode == media_seq_pkg::CMD_PIPE_SELECT;
  wire isFence = cmdValid && cmdCode == media_seq_pkg::CMD_PARTITION;
  wire isBase = cmdValid && cmdCode == media_seq_pkg::CMD_BASE_ADDR;
  wire isConst = cmdValid && cmdCode == media_seq_pkg::CMD_CONST_BUF;
  wire isPrim = cmdValid && cmdCode == media_seq_pkg::CMD_PRIMITIVE;
  wire isObj = cmdValid && cmdCode == media_seq_pkg::CMD_MEDIA_OBJ;
  wire isRegWr = cmdValid && cmdCode == media_seq_pkg::CMD_REG_WRITE;
  wire regHit = isRegWr && slotData == media_seq_pkg::VC_CTRL_OFFSET;
  wire isOtherState = cmdValid && (cmdCode == media_seq_pkg::CMD_STATE_PTRS ||
    cmdCode == media_seq_pkg::CMD_STREAMER_RB || cmdCode == media_seq_pkg::CMD_PRELOAD ||
    cmdCode == media_seq_pkg::CMD_SYS_ROUTINE || cmdCode == media_seq_pkg::CMD_VTX_ELEM ||
    cmdCode == media_seq_pkg::CMD_VTX_BUF);
  wire inConfig = phase == media_seq_pkg::ST_CONFIG;
  wire configReady = inConfig && ptrsSeen;

  // the address beat of a register write names its target in the data word
  assign slotData = cmdData;

  // phase advance: a step may only move forward, flush restarts the walk
  always_comb begin
    next_phase = phase;
    stepOk = 1'b1;
    unique case (phase)
      media_seq_pkg::ST_IDLE: stepOk = isFlush || isBase || isFence || isRegWr ||
        !cmdValid;
      media_seq_pkg::ST_FLUSHED: stepOk = !(isConst || isPrim || isObj || isOtherState);
      media_seq_pkg::ST_SELECTED: stepOk = isFence || isBase || isSelect || !cmdValid;
      media_seq_pkg::ST_FENCED: stepOk = !(isSelect || isConst || isPrim || isObj ||
        isOtherState);
      media_seq_pkg::ST_CONFIG: stepOk = !(isSelect || isFence) &&
        ((!isConst && !isPrim && !isObj) || ptrsSeen);
      media_seq_pkg::ST_CONST: stepOk = isPrim || isObj || isFlush || !cmdValid;
      media_seq_pkg::ST_PRIM: stepOk = isPrim || isObj || isFlush || !cmdValid;
    endcase
    if (isFlush) begin
      next_phase = media_seq_pkg::ST_FLUSHED;
    end else if (stepOk) begin
      if (isSelect) next_phase = media_seq_pkg::ST_SELECTED;
      // a context set-up fence before the first flush leaves the walk idle
      else if (isFence && phase != media_seq_pkg::ST_IDLE)
        next_phase = media_seq_pkg::ST_FENCED;
      else if (isBase && phase != media_seq_pkg::ST_SELECTED &&
        phase != media_seq_pkg::ST_IDLE) next_phase = media_seq_pkg::ST_CONFIG;
      else if (isConst) next_phase = media_seq_pkg::ST_CONST;
      else if (isPrim || isObj) next_phase = media_seq_pkg::ST_PRIM;
    end
  end

  // base address only opens configuration; other state needs it first
  assign stateBad = isOtherState && !inConfig;
  wire fenceTwice = isFence && fenceSeen;
  wire constTwice = isConst && constSeen;

  //------------------------------------------------------------
  // state slot write
  //------------------------------------------------------------
  assign slot.wrEn = stepOk && (isBase || (inConfig && cmdValid && (
    cmdCode == media_seq_pkg::CMD_STATE_PTRS || cmdCode == media_seq_pkg::CMD_STREAMER_RB ||
    cmdCode == media_seq_pkg::CMD_SYS_ROUTINE)));
  assign slot.wrIdx = isBase ? media_seq_pkg::SLOT_BASE :
    cmdCode == media_seq_pkg::CMD_STATE_PTRS ? media_seq_pkg::SLOT_PTRS :
    cmdCode == media_seq_pkg::CMD_STREAMER_RB ? media_seq_pkg::SLOT_STREAMER :
    media_seq_pkg::SLOT_ROUTINE;
  assign slot.wrData = cmdData;
  assign slot.rdIdx = readSlotSel[1:0];

  //------------------------------------------------------------
  // sequence tracking registers
  //------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      phase <= media_seq_pkg::ST_IDLE;
      fenceSeen <= 1'b0;
      constSeen <= 1'b0;
      ptrsSeen <= 1'b0;
    end else begin
      phase <= next_phase;
      fenceSeen <= isFlush ? 1'b0 : (fenceSeen || isFence);
      constSeen <= isFlush ? 1'b0 : (constSeen || isConst);
      ptrsSeen <= isFlush ? 1'b0 :
        (ptrsSeen || (inConfig && cmdValid && cmdCode == media_seq_pkg::CMD_STATE_PTRS));
    end
  end

  // outputs all registered; errors are one-cycle pulses per offending command
  always_ff @(posedge clk) begin
    if (srst) begin
      cmdAccept <= 1'b0;
      orderError <= 1'b0;
      undefinedError <= 1'b0;
      objectLaunch <= 1'b0;
      slotReadData <= 32'h00000000;
      phaseOut <= 3'h0;
    end else begin
      cmdAccept <= cmdValid && stepOk && !stateBad;
      orderError <= cmdValid && (!stepOk || stateBad);
      undefinedError <= fenceTwice || constTwice;
      objectLaunch <= isObj && stepOk && (configReady || phase == media_seq_pkg::ST_CONST ||
        phase == media_seq_pkg::ST_PRIM);
      slotReadData <= slot.rdData;
      phaseOut <= 3'(phase);
    end
  end

  //------------------------------------------------------------
  // vertex cache control register
  //------------------------------------------------------------
  // a register write is two beats: the address word, then its data word
  wire regAddrBeat = isRegWr && !regDataDue;
  wire regDataBeat = isRegWr && regDataDue;
  wire vcDataBeat = regDataBeat && regToVc;
  wire vcEnableWord = cmdData == media_seq_pkg::VC_ENABLE_DATA;
  wire next_regDataDue = regAddrBeat || (regDataDue && !regDataBeat);
  wire next_regToVc = regAddrBeat ? regHit : regToVc;

  // the pair may straddle idle beats; a write to any other address is dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      regDataDue <= 1'b0;
      regToVc <= 1'b0;
    end else begin
      regDataDue <= next_regDataDue;
      regToVc <= next_regToVc;
    end
  end

  // only the data word aimed at the control register moves streaming,
  // and it does so even when the sequencer refuses that register write as out of order
  always_ff @(posedge clk) begin
    if (srst) begin
      vertexCacheCtrl <= media_seq_pkg::VC_CTRL_RESET;
      vertexCacheStreaming <= 1'b0;
    end else if (vcDataBeat) begin
      vertexCacheCtrl <= cmdData;
      vertexCacheStreaming <= vcEnableWord;
    end
  end

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  flush_restart_a: assert property (@(posedge clk) disable iff (srst)
    isFlush |=> phase == media_seq_pkg::ST_FLUSHED) else $error("flush did not restart");
  order_flag_a: assert property (@(posedge clk) disable iff (srst)
    (cmdValid && !stepOk) |=> orderError && !cmdAccept) else $error("order fault missed");
  fence_twice_a: assert property (@(posedge clk) disable iff (srst)
    fenceTwice |=> undefinedError) else $error("second fence not flagged");
  const_twice_a: assert property (@(posedge clk) disable iff (srst)
    constTwice |=> undefinedError) else $error("second constant buffer not flagged");
  obj_launch_a: assert property (@(posedge clk) disable iff (srst)
    objectLaunch |-> $past(isObj)) else $error("launch without object");
  // cache control writes: streaming follows the word written, and the disable word lands in the register
  vc_enable_a: assert property (@(posedge clk) disable iff (srst)
    (vcDataBeat && cmdData == media_seq_pkg::VC_ENABLE_DATA) |=> vertexCacheStreaming)
    else $error("streaming not enabled");
  vc_disable_a: assert property (@(posedge clk) disable iff (srst)
    (vcDataBeat && cmdData == media_seq_pkg::VC_DISABLE_DATA) |=> !vertexCacheStreaming &&
    vertexCacheCtrl == media_seq_pkg::VC_DISABLE_DATA) else $error("streaming not disabled");
  // state outside configuration must be refused, never stored quietly
  state_refuse_a: assert property (@(posedge clk) disable iff (srst)
    stateBad |=> orderError && !cmdAccept) else $error("stray state command accepted");
endmodule

// [design/media_seq_pkg.sv]
// media command sequencer constants: command codes, register offset, field layout
// assumes the command producer presents one decoded command per beat
package media_seq_pkg;
  localparam int CMD_W = 5;
  localparam logic [4:0] CMD_FLUSH = 5'h01;
  localparam logic [4:0] CMD_PIPE_SELECT = 5'h02;
  localparam logic [4:0] CMD_PARTITION = 5'h03;
  localparam logic [4:0] CMD_BASE_ADDR = 5'h04;
  localparam logic [4:0] CMD_STATE_PTRS = 5'h05;
  localparam logic [4:0] CMD_STREAMER_RB = 5'h06;
  localparam logic [4:0] CMD_PRELOAD = 5'h07;
  localparam logic [4:0] CMD_SYS_ROUTINE = 5'h08;
  localparam logic [4:0] CMD_VTX_ELEM = 5'h09;
  localparam logic [4:0] CMD_VTX_BUF = 5'h0a;
  localparam logic [4:0] CMD_CONST_BUF = 5'h0b;
  localparam logic [4:0] CMD_PRIMITIVE = 5'h0c;
  localparam logic [4:0] CMD_MEDIA_OBJ = 5'h0d;
  localparam logic [4:0] CMD_REG_WRITE = 5'h0e;
  localparam logic [31:0] VC_CTRL_OFFSET = 32'h00002124;
  localparam logic [31:0] VC_CTRL_RESET = 32'h00000000;
  localparam int VC_ENABLE_BIT = 15;
  localparam logic [31:0] VC_DISABLE_DATA = 32'h01000000;
  localparam logic [31:0] VC_ENABLE_DATA = 32'h10001000;
  localparam int STATE_SLOTS = 4;
  localparam logic [1:0] SLOT_BASE = 2'h0;
  localparam logic [1:0] SLOT_PTRS = 2'h1;
  localparam logic [1:0] SLOT_STREAMER = 2'h2;
  localparam logic [1:0] SLOT_ROUTINE = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE, ST_FLUSHED, ST_SELECTED, ST_FENCED, ST_CONFIG, ST_CONST, ST_PRIM
  } phase_e;
endpackage

// [design/state_slot_if.sv]
// carrier between the sequencer and its state slot store
// assumes one clock shared by both ends
interface state_slot_if;
  logic wrEn;
  logic [1:0] wrIdx;
  logic [31:0] wrData;
  logic [1:0] rdIdx;
  logic [31:0] rdData;
  modport store (input wrEn, input wrIdx, input wrData, input rdIdx, output rdData);
  modport user (output wrEn, output wrIdx, output wrData, output rdIdx, input rdData);
endinterface

// [design/state_slot_store.sv]
// flip-flop store for repeatable state command payloads
// assumes synchronous active-high reset on the shared clock
module state_slot_store (
  input wire logic clk,
  input wire logic srst,
  state_slot_if.store slot
);
  logic [31:0] mem [media_seq_pkg::STATE_SLOTS];

  // later writes replace earlier ones, so the last command issued wins
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < media_seq_pkg::STATE_SLOTS; i++) begin
        mem[i] <= 32'h00000000;
      end
    end else if (slot.wrEn) begin
      mem[slot.wrIdx] <= slot.wrData;
    end
  end

  assign slot.rdData = mem[slot.rdIdx];
endmodule

// [bench/cmd_producer.sv]
// command producer model: one command beat per call
// assumes the sequencer samples the command port on rising clk
module cmd_producer (
  input wire logic clk,
  output logic cmdValid,
  output logic [4:0] cmdCode,
  output logic [31:0] cmdData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmdValid = 1'b0;
    cmdCode = 5'h1f;
    cmdData = 32'h0;
  end
  // drive after a falling edge and hold across the sampling edge
  task automatic issue(input logic [4:0] c, input logic [31:0] d);
    @(negedge clk);
    cmdValid = 1'b1;
    cmdCode = c;
    cmdData = d;
    @(negedge clk);
    cmdValid = 1'b0;
    cmdCode = ~c;  // released lines show the inverse, not a stale copy
    cmdData = ~d;
  endtask
endmodule

// [bench/tb.sv]
// bench top: table of in-order commands, then hand-written order cases
// assumes the producer model owns the command port
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [4:0] c; logic [31:0] d; logic a; logic [2:0] p; logic g;} row_s;
  logic clk, srst, cmdValid, cmdAccept, orderError, undefinedError;
  logic vertexCacheStreaming, objectLaunch;
  logic [4:0] cmdCode;
  logic [31:0] cmdData, readSlotSel, vertexCacheCtrl, slotReadData;
  logic [2:0] phaseOut;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  row_s rows [21];
  cmd_producer prod (.clk(clk), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData));
  media_pipe_command_sequencer dut (.clk(clk), .srst(srst), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .cmdData(cmdData), .readSlotSel(readSlotSel),
    .cmdAccept(cmdAccept), .orderError(orderError), .undefinedError(undefinedError),
    .vertexCacheCtrl(vertexCacheCtrl), .vertexCacheStreaming(vertexCacheStreaming),
    .objectLaunch(objectLaunch), .slotReadData(slotReadData), .phaseOut(phaseOut));
  // ------
  // helpers
  // ------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard: the whole run needs well under 300 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask
  task automatic step(input logic [4:0] c, input logic [31:0] d, input logic a,
                      input logic [2:0] p, input logic g);
    prod.issue(c, d);
    chk("cmdAccept", {31'h0, a}, {31'h0, cmdAccept});
    chk("orderError", {31'h0, ~a}, {31'h0, orderError});
    chk("objectLaunch", {31'h0, g}, {31'h0, objectLaunch});
    // phaseOut mirrors the phase register, so the new step shows one beat later
    @(negedge clk);
    chk("phaseOut", {29'h0, p}, {29'h0, phaseOut});
  endtask
  // ------
  // scenarios
  // ------
  initial begin
    rows = '{'{media_seq_pkg::CMD_PARTITION, 32'h0, 1'h1, 3'h0, 1'h0},
      '{media_seq_pkg::CMD_BASE_ADDR, 32'h33, 1'h1, 3'h0, 1'h0},
      '{media_seq_pkg::CMD_FLUSH, 32'h0, 1'h1, 3'h1, 1'h0},
      '{media_seq_pkg::CMD_REG_WRITE, 32'h00002124, 1'h1, 3'h1, 1'h0},
      '{media_seq_pkg::CMD_REG_WRITE, 32'h01000000, 1'h1, 3'h1, 1'h0},
      '{media_seq_pkg::CMD_FLUSH, 32'h0, 1'h1, 3'h1, 1'h0},
      '{media_seq_pkg::CMD_REG_WRITE, 32'h00002124, 1'h1, 3'h1, 1'h0},
      '{media_seq_pkg::CMD_REG_WRITE, 32'h10001000, 1'h1, 3'h1, 1'h0},
      '{media_seq_pkg::CMD_PIPE_SELECT, 32'h0, 1'h1, 3'h2, 1'h0},
      '{media_seq_pkg::CMD_PARTITION, 32'h0, 1'h1, 3'h3, 1'h0},
      '{media_seq_pkg::CMD_BASE_ADDR, 32'h11, 1'h1, 3'h4, 1'h0},
      '{media_seq_pkg::CMD_SYS_ROUTINE, 32'h0, 1'h1, 3'h4, 1'h0},
      '{media_seq_pkg::CMD_STATE_PTRS, 32'h22, 1'h1, 3'h4, 1'h0},
      '{media_seq_pkg::CMD_STREAMER_RB, 32'h1, 1'h1, 3'h4, 1'h0},
      '{media_seq_pkg::CMD_PRELOAD, 32'h0, 1'h1, 3'h4, 1'h0},
      '{media_seq_pkg::CMD_VTX_ELEM, 32'h0, 1'h1, 3'h4, 1'h0},
      '{media_seq_pkg::CMD_VTX_BUF, 32'h20, 1'h1, 3'h4, 1'h0},
      '{media_seq_pkg::CMD_CONST_BUF, 32'h0, 1'h1, 3'h5, 1'h0},
      '{media_seq_pkg::CMD_PRIMITIVE, 32'h1, 1'h1, 3'h6, 1'h0},
      '{media_seq_pkg::CMD_MEDIA_OBJ, 32'h0, 1'h1, 3'h6, 1'h1},
      '{media_seq_pkg::CMD_MEDIA_OBJ, 32'h0, 1'h1, 3'h6, 1'h1}};
    srst = 1'b1;
    readSlotSel = 32'h0;
    repeat (4) @(negedge clk);
    chk("phaseOut", 32'h0, {29'h0, phaseOut});
    chk("vertexCacheCtrl", 32'h0, vertexCacheCtrl);
    srst = 1'b0;
    // a state command before any flush is refused
    step(media_seq_pkg::CMD_STATE_PTRS, 32'h0, 1'h0, 3'h0, 1'h0);
    foreach (rows[i]) begin
      step(rows[i].c, rows[i].d, rows[i].a, rows[i].p, rows[i].g);
      if (rows[i].c == media_seq_pkg::CMD_REG_WRITE)
        chk("streaming", {31'h0, rows[i].d == 32'h10001000}, {31'h0, vertexCacheStreaming});
      if (rows[i].d == 32'h01000000)
        chk("vertexCacheCtrl", 32'h01000000, vertexCacheCtrl);
    end
    chk("vertexCacheCtrl", 32'h10001000, vertexCacheCtrl);
    // objects stop being launched once a new flush arrives
    step(media_seq_pkg::CMD_FLUSH, 32'h0, 1'h1, 3'h1, 1'h0);
    step(media_seq_pkg::CMD_MEDIA_OBJ, 32'h0, 1'h0, 3'h1, 1'h0);
    step(media_seq_pkg::CMD_BASE_ADDR, 32'haa, 1'h1, 3'h4, 1'h0);
    step(media_seq_pkg::CMD_BASE_ADDR, 32'hbb, 1'h1, 3'h4, 1'h0);
    readSlotSel = {30'h0, media_seq_pkg::SLOT_BASE};
    repeat (2) @(negedge clk);
    chk("slotReadData", 32'hbb, slotReadData);
    // second fence after one select
    step(media_seq_pkg::CMD_FLUSH, 32'h0, 1'h1, 3'h1, 1'h0);
    step(media_seq_pkg::CMD_PIPE_SELECT, 32'h0, 1'h1, 3'h2, 1'h0);
    step(media_seq_pkg::CMD_PARTITION, 32'h0, 1'h1, 3'h3, 1'h0);
    prod.issue(media_seq_pkg::CMD_PARTITION, 32'h0);
    chk("undefinedError", 32'h1, {31'h0, undefinedError});
    // second constant buffer with no flush between
    step(media_seq_pkg::CMD_FLUSH, 32'h0, 1'h1, 3'h1, 1'h0);
    step(media_seq_pkg::CMD_BASE_ADDR, 32'h0, 1'h1, 3'h4, 1'h0);
    step(media_seq_pkg::CMD_STATE_PTRS, 32'h0, 1'h1, 3'h4, 1'h0);
    step(media_seq_pkg::CMD_CONST_BUF, 32'h0, 1'h1, 3'h5, 1'h0);
    prod.issue(media_seq_pkg::CMD_CONST_BUF, 32'h0);
    chk("undefinedError", 32'h1, {31'h0, undefinedError});
    summarize();
  end
endmodule
